// [cdm_pkg.sv]
/*
 * cdm_pkg: constants, register map and carrier types for the current
 * detect and monitor select block.
 * assumes: one 10 MHz clock; all measured quantities arrive already
 * synchronous to that clock from the controller's sampling logic.
 */
package cdm_pkg;
    // clock and time base
    localparam int CLK_HZ = 10_000_000;          // hclk rate
    localparam int TICK_MS = 10;                 // timer resolution, ms
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int MIN_ON_MS = 100;              // least on-time of a flag
    localparam int MIN_ON_TICKS = MIN_ON_MS / TICK_MS;

    // current units are 0.01 % of rated current
    localparam logic [15:0] LEVEL_MAX = 16'h4e20;    // 200.00 %
    localparam logic [15:0] LOW_HYST = 16'h01f4;     // 5.00 %
    localparam logic [15:0] TIMER_MIN = 16'h0001;    // 0.01 s
    localparam logic [15:0] TIMER_MAX = 16'hea60;    // 600.00 s
    localparam logic [7:0] FILTER_TC_MAX = 8'h32;    // 5.0 s in 0.1 s
    localparam logic [31:0] FEED_SAT = 32'h0000270f; // 999.9 min

    // reset values
    localparam logic [15:0] LEVEL_RST = 16'h0000;    // disabled
    localparam logic [15:0] TIMER_RST = 16'h0064;    // 1.00 s
    localparam logic [1:0] MCHAR_RST = 2'h1;
    localparam logic [7:0] POLE_RST = 8'h04;
    localparam logic [15:0] COEFF_RST = 16'h0001;

    // register byte offsets
    localparam logic [7:0] OFS_WARN_LEVEL = 8'h00;
    localparam logic [7:0] OFS_LEVEL_1 = 8'h04;
    localparam logic [7:0] OFS_TIMER_1 = 8'h08;
    localparam logic [7:0] OFS_LEVEL_2_LOW = 8'h0c;
    localparam logic [7:0] OFS_TIMER_2_LOW = 8'h10;
    localparam logic [7:0] OFS_LEVEL_3 = 8'h14;
    localparam logic [7:0] OFS_TIMER_3 = 8'h18;
    localparam logic [7:0] OFS_MOTOR_CHAR = 8'h1c;
    localparam logic [7:0] OFS_FILTER_TC = 8'h20;
    localparam logic [7:0] OFS_MON_SEL = 8'h24;
    localparam logic [7:0] OFS_SPEED_COEFF = 8'h28;
    localparam logic [7:0] OFS_TRANSPORT_COEFF = 8'h2c;
    localparam logic [7:0] OFS_POLE_COUNT = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_MONITOR = 8'h38;

    // monitor select field: item in [7:0], speed format in [10:8]
    localparam int MON_ITEM_LSB = 0;
    localparam int MON_FMT_LSB = 8;

    // monitor item codes
    typedef enum logic [7:0] {
        ITEM_SPEED = 8'h00,
        ITEM_CURRENT = 8'h03,
        ITEM_VOLTAGE = 8'h04,
        ITEM_TORQUE = 8'h08,
        ITEM_POWER = 8'h09,
        ITEM_PID = 8'h0a
    } cdm_item_t;

    // speed sub-format codes
    typedef enum logic [2:0] {
        FMT_FOUT1 = 3'h0,
        FMT_FOUT2 = 3'h1,
        FMT_FREF = 3'h2,
        FMT_MOTOR = 3'h3,
        FMT_LOAD = 3'h4,
        FMT_LINE = 3'h5,
        FMT_TRANSPORT = 3'h6,
        FMT_PERCENT = 3'h7
    } cdm_fmt_t;

    // measured quantities, frequencies in 0.01 Hz
    typedef struct packed {
        logic [15:0] iout_pct;   // output current, 0.01 % rated
        logic [15:0] iout_rms;   // output current rms
        logic [15:0] vout_rms;   // output voltage rms
        logic [15:0] torque;     // calculated torque %
        logic [15:0] pin;        // input power
        logic [15:0] pid_cmd;    // pid command
        logic [15:0] fout1;      // before slip compensation
        logic [15:0] fout2;      // after slip compensation
        logic [15:0] fref;       // reference (set) frequency
        logic [15:0] fmax;       // maximum frequency
    } cdm_meas_t;

    // detection flags
    typedef struct packed {
        logic low_current_detected;
        logic current_detected_3;
        logic current_detected_2;
        logic current_detected_1;
        logic overload_early_warning;
    } cdm_flags_t;
endpackage

// [cdm_current_monitor.sv]
/*
 * cdm_current_monitor: current comparison flags with persistence timers,
 * hysteresis and least on-time, plus keypad monitor scaling, filtering
 * and selection, with an ahb-lite register slave.
 * assumes: single ahb-lite master, single word transfers only; the
 * measured inputs come from logic on hclk, so they are not synchronised.
 */
// How it works
// - level zero disables; else 1 to 200 %
// - motor characteristic 1 or 2 to thermal model
// - warning flag on while current above level
// - over-current flag after unbroken timer period
// - over-current flag clears below 90 % level
// - every detected flag stays on 100 ms least
// - low flag after current below level timer
// - low flag clears above level plus 5 %
// - smoothing filter 0-5 s except speed item
// - item codes 3,4,8,9,10 select quantities
// - speed item uses sub-format codes 0 to 7
// - motor speed is frequency times 120 over poles
// - load and line speed are coefficient times frequency
// - transport time is coefficient over frequency product
// - feeding time saturates at 999.9 minutes
// - setting shows set frequency, running shows output, for speed formats 3 to 7 only
// - persistence timers 0.01 to 600.00 seconds
module cdm_current_monitor
#(
    parameter int TICK_LEN = cdm_pkg::TICK_CYCLES   // cycles per 10 ms tick
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // measured quantities and display mode
    input wire cdm_pkg::cdm_meas_t meas,
    input wire logic show_setting,
    // results
    output cdm_pkg::cdm_flags_t flags,
    output logic [31:0] monitor_value,
    output logic [1:0] thermal_char
);
    import cdm_pkg::*;

    // configuration registers
    logic [15:0] warn_current_level_ff;
    logic [15:0] level_ff [3];           // levels 1, 2/low, 3
    logic [15:0] timer_ff [3];           // timers 1, 2/low, 3 in 10 ms
    logic [1:0] mchar_ff;                // motor characteristic
    logic [7:0] display_filter_tc_ff;    // 0.1 s units
    logic [7:0] monitor_item_select_ff;
    logic [2:0] speed_format_select_ff;
    logic [15:0] speed_display_coeff_ff;
    logic [15:0] transport_time_coeff_ff;
    logic [7:0] motor_pole_count_ff;
    // bus data phase state
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    // time base
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    // flags and monitor
    logic warn_ff;
    logic [3:0] det_ff;                  // 1, 2, 3, low
    logic [31:0] filt_ff;
    logic [31:0] monitor_ff;

    // address phase qualifier
    logic addr_ok;
    assign addr_ok = hsel & htrans[1] & hready;

    // level writes clamp to the legal span; zero passes as disabled
    function automatic logic [15:0] clamp_level(input logic [31:0] v);
        clamp_level = (v > {16'h0000, LEVEL_MAX}) ? LEVEL_MAX : v[15:0];
    endfunction

    // timer writes clamp into 0.01 .. 600.00 s
    function automatic logic [15:0] clamp_timer(input logic [31:0] v);
        clamp_timer = (v < {16'h0000, TIMER_MIN}) ? TIMER_MIN :
            (v > {16'h0000, TIMER_MAX}) ? TIMER_MAX : v[15:0];
    endfunction

    // bus handshake: ready from the first edge after reset, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else
        begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= addr_ok ? haddr : wr_addr_ff;
        end
    end

    // register writes land in the data phase with hwdata
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            warn_current_level_ff <= LEVEL_RST;
            for (int i = 0; i < 3; i++)
            begin
                level_ff[i] <= LEVEL_RST;
                timer_ff[i] <= TIMER_RST;
            end
            mchar_ff <= MCHAR_RST;
            display_filter_tc_ff <= 8'h00;
            monitor_item_select_ff <= 8'h00;
            speed_format_select_ff <= 3'h0;
            speed_display_coeff_ff <= COEFF_RST;
            transport_time_coeff_ff <= COEFF_RST;
            motor_pole_count_ff <= POLE_RST;
        end
        else if (wr_pend_ff)
        begin
            case (wr_addr_ff)
                OFS_WARN_LEVEL: warn_current_level_ff <= clamp_level(hwdata);
                OFS_LEVEL_1: level_ff[0] <= clamp_level(hwdata);
                OFS_TIMER_1: timer_ff[0] <= clamp_timer(hwdata);
                OFS_LEVEL_2_LOW: level_ff[1] <= clamp_level(hwdata);
                OFS_TIMER_2_LOW: timer_ff[1] <= clamp_timer(hwdata);
                OFS_LEVEL_3: level_ff[2] <= clamp_level(hwdata);
                OFS_TIMER_3: timer_ff[2] <= clamp_timer(hwdata);
                // only codes 1 and 2 are legal; others are ignored
                OFS_MOTOR_CHAR: mchar_ff <= (hwdata == 32'h1 || hwdata == 32'h2) ?
                    hwdata[1:0] : mchar_ff;
                OFS_FILTER_TC: display_filter_tc_ff <= (hwdata > {24'h0, FILTER_TC_MAX}) ?
                    FILTER_TC_MAX : hwdata[7:0];
                OFS_MON_SEL:
                begin
                    monitor_item_select_ff <= hwdata[MON_ITEM_LSB +: 8];
                    speed_format_select_ff <= hwdata[MON_FMT_LSB +: 3];
                end
                OFS_SPEED_COEFF: speed_display_coeff_ff <= hwdata[15:0];
                OFS_TRANSPORT_COEFF: transport_time_coeff_ff <= hwdata[15:0];
                // a zero pole count would divide by zero
                OFS_POLE_COUNT: motor_pole_count_ff <= (hwdata[7:0] == 8'h00) ?
                    POLE_RST : hwdata[7:0];
                default: ;
            endcase
        end
    end

    // read data is fetched in the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_ff <= 32'h0;
        else if (addr_ok & ~hwrite)
        begin
            case (haddr)
                OFS_WARN_LEVEL: hrdata_ff <= {16'h0, warn_current_level_ff};
                OFS_LEVEL_1: hrdata_ff <= {16'h0, level_ff[0]};
                OFS_TIMER_1: hrdata_ff <= {16'h0, timer_ff[0]};
                OFS_LEVEL_2_LOW: hrdata_ff <= {16'h0, level_ff[1]};
                OFS_TIMER_2_LOW: hrdata_ff <= {16'h0, timer_ff[1]};
                OFS_LEVEL_3: hrdata_ff <= {16'h0, level_ff[2]};
                OFS_TIMER_3: hrdata_ff <= {16'h0, timer_ff[2]};
                OFS_MOTOR_CHAR: hrdata_ff <= {30'h0, mchar_ff};
                OFS_FILTER_TC: hrdata_ff <= {24'h0, display_filter_tc_ff};
                OFS_MON_SEL: hrdata_ff <= {21'h0, speed_format_select_ff,
                    monitor_item_select_ff};
                OFS_SPEED_COEFF: hrdata_ff <= {16'h0, speed_display_coeff_ff};
                OFS_TRANSPORT_COEFF: hrdata_ff <= {16'h0, transport_time_coeff_ff};
                OFS_POLE_COUNT: hrdata_ff <= {24'h0, motor_pole_count_ff};
                OFS_STATUS: hrdata_ff <= {27'h0, det_ff, warn_ff};
                OFS_MONITOR: hrdata_ff <= monitor_ff;
                default: hrdata_ff <= 32'h0;   // unmapped reads as zero
            endcase
        end
    end

    // 10 ms tick drives all timers and the display filter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (tick_cnt_ff == 32'(TICK_LEN - 1));
            tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_LEN - 1)) ? 32'h0 : tick_cnt_ff + 32'h1;
        end
    end

    // warning follows the comparison directly, no timer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            warn_ff <= 1'b0;
        else
            warn_ff <= (warn_current_level_ff != 16'h0) &&
                (meas.iout_pct > warn_current_level_ff);
    end

    // one detector per flag: 0..2 over-current, 3 low-current
    for (genvar g = 0; g < 4; g++)
    begin : g_det
        localparam int LI = (g == 3) ? 1 : g;   // low shares level 2
        logic [15:0] lvl;
        logic [17:0] lvl_x9;
        logic on_cond;
        logic off_cond;
        logic [15:0] pers_ff;
        logic [7:0] hold_ff;
        assign lvl = level_ff[LI];
        assign lvl_x9 = {2'b00, lvl} * 18'd9;
        // over-current: on strictly above; low-current: on strictly below
        assign on_cond = (lvl != 16'h0) && ((g < 3) ? (meas.iout_pct > lvl) :
            (meas.iout_pct < lvl));
        // current*10 needs 20 bits, else a large current wraps and clears
        assign off_cond = (g < 3) ?
            ({4'h0, meas.iout_pct} * 20'd10 < {2'b00, lvl_x9}) :
            ({1'b0, meas.iout_pct} > ({1'b0, lvl} + {1'b0, LOW_HYST}));

        // persistence count and flag with least on-time
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                pers_ff <= 16'h0;
                hold_ff <= 8'h0;
                det_ff[g] <= 1'b0;
            end
            else if (!det_ff[g])
            begin
                if (!on_cond)
                    pers_ff <= 16'h0;
                else if (tick_ff)
                begin
                    if (pers_ff + 16'h1 >= timer_ff[LI])
                    begin
                        det_ff[g] <= 1'b1;
                        hold_ff <= 8'(MIN_ON_TICKS);
                        pers_ff <= 16'h0;
                    end
                    else
                        pers_ff <= pers_ff + 16'h1;
                end
            end
            else
            begin
                if (tick_ff && hold_ff != 8'h0)
                    hold_ff <= hold_ff - 8'h1;
                if (hold_ff == 8'h0 && off_cond)
                    det_ff[g] <= 1'b0;
            end
        end
    end

    // speed scaling; set frequency when showing a setting
    logic [15:0] fsel;
    logic [31:0] motor_rpm, load_speed, feed_den, feed_time, speed_pct, speed_val;
    assign fsel = show_setting ? meas.fref : meas.fout1;
    assign motor_rpm = ({16'h0, fsel} * 32'd120) / {24'h0, motor_pole_count_ff};
    assign load_speed = {16'h0, speed_display_coeff_ff} * {16'h0, fsel};
    assign feed_den = {16'h0, fsel} * {16'h0, transport_time_coeff_ff};
    // zero divisor or too long a time both show the ceiling
    assign feed_time = (feed_den == 32'h0) ? FEED_SAT :
        ({16'h0, speed_display_coeff_ff} * 32'd1000) / feed_den;
    assign speed_pct = (meas.fmax == 16'h0) ? 32'h0 :
        ({16'h0, fsel} * 32'd10000) / {16'h0, meas.fmax};

    // speed sub-format choice
    always_comb
    begin
        case (cdm_fmt_t'(speed_format_select_ff))
            FMT_FOUT1: speed_val = {16'h0, meas.fout1};
            FMT_FOUT2: speed_val = {16'h0, meas.fout2};
            FMT_FREF: speed_val = {16'h0, meas.fref};
            FMT_MOTOR: speed_val = motor_rpm;
            FMT_LOAD: speed_val = load_speed;
            FMT_LINE: speed_val = load_speed;
            FMT_TRANSPORT: speed_val = (feed_time >= FEED_SAT) ? FEED_SAT : feed_time;
            FMT_PERCENT: speed_val = speed_pct;
            default: speed_val = 32'h0;
        endcase
    end

    // item choice for the non-speed quantities
    logic [31:0] item_val;
    always_comb
    begin
        case (monitor_item_select_ff)
            ITEM_CURRENT: item_val = {16'h0, meas.iout_rms};
            ITEM_VOLTAGE: item_val = {16'h0, meas.vout_rms};
            ITEM_TORQUE: item_val = {16'h0, meas.torque};
            ITEM_POWER: item_val = {16'h0, meas.pin};
            ITEM_PID: item_val = {16'h0, meas.pid_cmd};
            default: item_val = 32'h0;
        endcase
    end

    // first-order smoothing, one step per tick; integer step trades
    // a small residual offset for a divider instead of a multiplier
    logic signed [32:0] filt_diff;
    logic [15:0] filt_den;
    assign filt_diff = $signed({1'b0, item_val}) - $signed({1'b0, filt_ff});
    assign filt_den = {8'h0, display_filter_tc_ff} * 16'd10 + 16'd1;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            filt_ff <= 32'h0;
        else if (tick_ff)
            filt_ff <= 32'($signed({1'b0, filt_ff}) +
                filt_diff / $signed({17'h0, filt_den}));
    end

    // displayed value: speed item bypasses the filter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            monitor_ff <= 32'h0;
        else
            monitor_ff <= (monitor_item_select_ff == ITEM_SPEED) ?
                speed_val : filt_ff;
    end

    // outputs straight from flip-flops, except hresp tied to okay
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign flags = {det_ff, warn_ff};
    assign monitor_value = monitor_ff;
    assign thermal_char = mchar_ff;
endmodule

// [cdm_current_monitor_props.sv]
/* cdm_current_monitor_props: port checker for the current monitor.
   assumes: bound to cdm_current_monitor; word-only ahb writes. */
module cdm_current_monitor_props
import cdm_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    // observed data
    input wire cdm_pkg::cdm_meas_t meas,
    input wire cdm_pkg::cdm_flags_t flags,
    input wire logic [1:0] thermal_char
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] reg_ff [16]; // shadow of written words
    logic [3:0] wa_ff; // pending write slot
    logic wp_ff; // write data phase
    int on_ff [5]; // cycles each flag stood high
    int run_ff; // unbroken cycles above level 1
    // shadow writes land in the data phase, as in the block
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp_ff <= 1'b0;
            wa_ff <= 4'h0;
            for (int i = 0; i < 16; i++) reg_ff[i] <= 32'h0;
        end
        else
        begin
            wp_ff <= hsel && htrans[1] && hready && hwrite;
            wa_ff <= haddr[5:2];
            if (wp_ff) reg_ff[wa_ff] <= hwdata;
        end
    end
    // run lengths; a zero level never counts, since it disables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_ff <= 0;
            for (int i = 0; i < 5; i++) on_ff[i] <= 0;
        end
        else
        begin
            run_ff <= (reg_ff[1] != 0 && {16'h0, meas.iout_pct} > reg_ff[1]) ? run_ff + 1 : 0;
            for (int i = 0; i < 5; i++) on_ff[i] <= flags[i] ? on_ff[i] + 1 : 0;
        end
    end
    property p_char; thermal_char == 2'h1 || thermal_char == 2'h2; endproperty
    a_char: assert property (p_char) else $error("bad motor characteristic");
    property p_warn; $stable(reg_ff[0]) && $past(hresetn) |-> flags.overload_early_warning ==
        (reg_ff[0] != 0 && {16'h0, $past(meas.iout_pct)} > reg_ff[0]); endproperty
    a_warn: assert property (p_warn) else $error("warning flag wrong");
    property p_set; $rose(flags.current_detected_1) |-> reg_ff[1] != 0 &&
        run_ff >= (int'(reg_ff[2]) - 1) * TICK_LEN; endproperty
    a_set: assert property (p_set) else $error("detect flag early");
    property p_off; $fell(flags.current_detected_1) |->
        $past(meas.iout_pct) * 10 < reg_ff[1] * 9; endproperty
    a_off: assert property (p_off) else $error("detect flag dropped early");
    property p_lset; $rose(flags.low_current_detected) |->
        reg_ff[3] != 0 && $past(meas.iout_pct) < reg_ff[3]; endproperty
    a_lset: assert property (p_lset) else $error("low flag wrong set");
    property p_loff; $fell(flags.low_current_detected) |->
        $past(meas.iout_pct) > reg_ff[3] + LOW_HYST; endproperty
    a_loff: assert property (p_loff) else $error("low flag dropped early");
    property p_hold1; $fell(flags.current_detected_1) |->
        on_ff[1] >= (MIN_ON_TICKS - 1) * TICK_LEN; endproperty
    a_hold1: assert property (p_hold1) else $error("detect flag too short");
    property p_hold4; $fell(flags.low_current_detected) |->
        on_ff[4] >= (MIN_ON_TICKS - 1) * TICK_LEN; endproperty
    a_hold4: assert property (p_hold4) else $error("low flag too short");
    c_set: cover property ($rose(flags.current_detected_1));
    c_low: cover property ($fell(flags.low_current_detected));
    c_warn: cover property ($rose(flags.overload_early_warning));
endmodule

bind cdm_current_monitor cdm_current_monitor_props #(.TICK_LEN(TICK_LEN)) cdm_current_monitor_props_i
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .meas(meas), .flags(flags),
    .thermal_char(thermal_char)
);

// [cdm_keypad_model.sv]
/* cdm_keypad_model: keypad display and output terminals.
   assumes: fed from the block's result ports on hclk. */
module cdm_keypad_model
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // results, and what the operator sees
    input wire cdm_pkg::cdm_flags_t flags,
    input wire logic [31:0] monitor_value,
    output logic [31:0] shown_ff,
    output logic [4:0] term_ff
);
    // scanned display: one cycle late, like a real keypad latch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        shown_ff <= !hresetn ? 32'h0 : monitor_value;
        term_ff <= !hresetn ? 5'h0 : flags;
    end
endmodule

// [cdm_current_monitor_tb.sv]
/* cdm_current_monitor_tb: bench for the current monitor.
   assumes: tick shortened to 10 cycles; bus master modelled by tasks. */
module cdm_current_monitor_tb
import cdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TL = 10; // short tick keeps timers quick
    logic hclk, hresetn, hsel, hwrite, show_setting, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans, thermal_char;
    logic [31:0] hwdata, hrdata, monitor_value, shown, q;
    logic [4:0] term;
    cdm_meas_t meas;
    cdm_flags_t flags;
    int num_errors = 0;
    int checks = 0;
    cdm_current_monitor #(.TICK_LEN(TL)) cdm_current_monitor_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .meas(meas), .show_setting(show_setting), .flags(flags),
        .monitor_value(monitor_value), .thermal_char(thermal_char));
    cdm_keypad_model cdm_keypad_model_i (.hclk(hclk), .hresetn(hresetn), .flags(flags),
        .monitor_value(monitor_value), .shown_ff(shown), .term_ff(term));
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one single ahb transfer; read data taken at the data-phase edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cur(input logic [15:0] v);
        @(posedge hclk);
        meas.iout_pct <= v;
    endtask
    // waits at most n cycles for flag b to reach v
    task automatic wf(input int b, input logic v, input int n, output int t);
        for (t = 0; flags[b] !== v && t < n; t++) @(posedge hclk);
    endtask
    task automatic t_regs();
        bus(OFS_TIMER_1, 1'b0, 32'h0);
        chk(q, {16'h0, TIMER_RST});
        bus(8'h3c, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(OFS_MOTOR_CHAR, 1'b1, 32'h3);
        bus(OFS_MOTOR_CHAR, 1'b0, 32'h0);
        chk(q, 32'h1);
        bus(OFS_MOTOR_CHAR, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
        chk({30'h0, thermal_char}, 32'h2);
        bus(OFS_LEVEL_1, 1'b1, 32'd30000);
        bus(OFS_LEVEL_1, 1'b0, 32'h0);
        chk(q, {16'h0, LEVEL_MAX});
    endtask
    task automatic t_warn();
        bus(OFS_WARN_LEVEL, 1'b1, 32'd8500); // 85 % of a 100 % overload level
        cur(16'd8501);
        repeat (3) @(posedge hclk);
        chk(term[0], 1'b1);
        cur(16'd8500);
        repeat (3) @(posedge hclk);
        chk(term[0], 1'b0);
        bus(OFS_WARN_LEVEL, 1'b1, 32'h0);
        cur(16'd19000);
        repeat (3) @(posedge hclk);
        chk(term[0], 1'b0);
    endtask
    // a broken run must restart the timer; then hysteresis and hold
    task automatic t_det();
        int t;
        bus(OFS_TIMER_1, 1'b1, 32'd5);
        bus(OFS_LEVEL_1, 1'b1, 32'd10000);
        cur(16'd10001);
        repeat (25) @(posedge hclk);
        cur(16'd0);
        cur(16'd10001);
        wf(1, 1'b1, 100, t);
        chk(32'(t >= 4 * TL), 32'h1);
        cur(16'd9001);
        repeat (150) @(posedge hclk);
        chk(flags.current_detected_1, 1'b1);
        cur(16'd8999);
        repeat (3) @(posedge hclk);
        chk(flags.current_detected_1, 1'b0);
        cur(16'd10001);
        wf(1, 1'b1, 100, t);
        cur(16'd0);
        repeat (8 * TL) @(posedge hclk);
        chk(flags.current_detected_1, 1'b1);
        wf(1, 1'b0, 4 * TL, t);
        chk(flags.current_detected_1, 1'b0);
    endtask
    task automatic t_low();
        int t;
        bus(OFS_TIMER_2_LOW, 1'b1, 32'd2);
        bus(OFS_LEVEL_2_LOW, 1'b1, 32'd5000);
        cur(16'd4999);
        wf(4, 1'b1, 50, t);
        chk(flags.low_current_detected, 1'b1);
        cur(16'd5500);
        repeat (150) @(posedge hclk);
        chk(flags.low_current_detected, 1'b1);
        cur(16'd5501);
        repeat (3) @(posedge hclk);
        chk(flags.low_current_detected, 1'b0);
    endtask
    // item table, then every speed format; fmt 6 divides by zero
    task automatic t_mon();
        logic [7:0] it [5] = '{8'h3, 8'h4, 8'h8, 8'h9, 8'ha};
        logic [31:0] sp [8] = '{5000, 4900, 3000, 150000, 15000, 15000, FEED_SAT, 5000};
        for (int i = 0; i < 5; i++)
        begin
            bus(OFS_MON_SEL, 1'b1, {24'h0, it[i]});
            repeat (3 * TL) @(posedge hclk);
            chk(shown, {16'h0, it[i] + 8'h1, it[i]});
        end
        bus(OFS_FILTER_TC, 1'b1, 32'h1);
        bus(OFS_MON_SEL, 1'b1, 32'h3);
        repeat (3 * TL) @(posedge hclk);
        chk(32'(shown !== 32'h0403), 32'h1);
        bus(OFS_SPEED_COEFF, 1'b1, 32'd3);
        bus(OFS_TRANSPORT_COEFF, 1'b1, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            bus(OFS_MON_SEL, 1'b1, 32'(i) << MON_FMT_LSB);
            repeat (4) @(posedge hclk);
            chk(shown, sp[i]);
        end
        bus(OFS_MON_SEL, 1'b1, 32'h300);
        show_setting <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(shown, 32'd90000);
    endtask
    task automatic results();
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        {hresetn, hsel, hwrite, show_setting, haddr, htrans, hwdata} = '0;
        meas = {16'h0, 16'h0403, 16'h0504, 16'h0908, 16'h0a09, 16'h0b0a,
            16'd5000, 16'd4900, 16'd3000, 16'd10000};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs();
        t_warn();
        t_det();
        t_low();
        t_mon();
        results();
    end
    // whole run is near 900 cycles; a hang is cut well past that
    initial
    begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        results();
    end
endmodule
